// >>> core/ecpf_pkg.sv
// ecpf_pkg: constants and types shared by the ecp transfer engine
// assumes a single 250 MHz clock domain
package ecpf_pkg;
    // ---------------------------------------------------------------
    // modes of the port mode field
    // ---------------------------------------------------------------
    localparam logic [2:0] MODE_STD   = 3'h0;
    localparam logic [2:0] MODE_BIDIR = 3'h1;
    localparam logic [2:0] MODE_FIFO  = 3'h2;
    localparam logic [2:0] MODE_ECP   = 3'h3;

    // ---------------------------------------------------------------
    // fifo and command byte layout
    // ---------------------------------------------------------------
    localparam int         QUEUE_DEPTH  = 16;
    localparam int         LEVEL_W      = 5;
    localparam int         CMD_KIND_BIT = 7;
    localparam logic [LEVEL_W-1:0] LEVEL_ONE = 5'h01;
    localparam logic [6:0] RUN_ZERO      = 7'h00;
    localparam int         DMA_BURST_MAX = 32;
    localparam logic [5:0] BURST_ONE     = 6'h01;

    // ---------------------------------------------------------------
    // handshake timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 4;
    localparam int STROBE_HOLD_NS = 500;
    localparam int STROBE_CYCLES  = (STROBE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ldrq encodings are taken by a serialiser outside this block
    typedef struct packed {
        logic       is_cmd;   // 1: command byte (host ack low)
        logic [7:0] value;
    } ecpf_entry_s;
endpackage

// >>> core/ecpf_fifo.sv
// ecpf_fifo: flop based fifo, valid/ready on both sides
// assumes synchronous use on mclk; flush clears it
`timescale 1ns/1ps
module ecpf_fifo
    import ecpf_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               flush,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire logic [WIDTH-1:0]   in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output logic [WIDTH-1:0]        out_data,
    output logic [$clog2(DEPTH):0]  level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // -----------------------------------------------------------------
    // handshake
    // -----------------------------------------------------------------
    assign in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;

    // storage, written by index
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count; wrap relies on power of two depth
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// >>> core/ecpf_sync.sv
// ecpf_sync: three flop synchroniser for pin inputs
// assumes asynchronous input; change counts once stages two and three agree
`timescale 1ns/1ps
module ecpf_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // first stage feeds only the second
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            lvl_q <= INIT;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end
    assign level = lvl_q;
endmodule

// >>> core/ecpf_engine.sv
// Behaviour
// - command port sends commands in ecp mode (data in fifo mode), data port sends data
// - reverse: handshake peripheral bytes until fifo full
// - forward host ack high data, low command
// - command bit 7: 0 run count, 1 address
// - reverse periph ack low marks command byte
// - run count n replicates next byte n+1
// - control drivers open drain in mode 000
// - host side never stalls, byte transfers
// - mask bit suppresses dma and service interrupts
// - unmasking with condition true interrupts at once
// - terminal count interrupts and sets mask
// - forward pio: interrupt on enough free space
// - reverse pio: interrupt on enough fill
// - fault falling edge or enable clear interrupts
// - ack rising edge interrupts when enabled
// - fifo only active in fifo or ecp mode
// - threshold equals trigger setting plus one
// - dma request bursts at most 32 cycles
// - reverse dma requests whenever fifo holds data
//
// ecpf_engine: ecp parallel port transfer engine, fifo and service logic
// assumes host strobes are one-cycle pulses on mclk; pins are asynchronous
`timescale 1ns/1ps
module ecpf_engine
    import ecpf_pkg::*;
#(
    parameter int DEPTH = QUEUE_DEPTH,
    parameter int BUF_DEPTH = 32
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    // host side
    input  wire logic [2:0] mode,
    input  wire logic       direction,
    input  wire logic       service_interrupt_mask,
    input  wire logic       dma_request_enable,
    input  wire logic       fault_irq_enable_low,
    input  wire logic       acknowledge_irq_enable,
    input  wire logic [3:0] queue_trigger_setting,
    input  wire logic       command_byte_queue_port,
    input  wire logic       data_byte_queue_port,
    input  wire logic [7:0] host_wdata,
    input  wire logic       host_read,
    output logic [7:0]      host_rdata,
    input  wire logic       dma_ack,
    input  wire logic       dma_tc,
    output logic            dma_request,
    output logic            mask_set,
    output logic            irq,
    output logic            queue_full,
    output logic            queue_empty,
    // peripheral pins
    input  wire logic [7:0] pd_in,
    output logic [7:0]      pd_out,
    output logic            pd_oe,
    output logic            strobe_low_out,
    output logic            strobe_low_oe,
    output logic            host_ack_out,
    output logic            host_ack_oe,
    input  wire logic       periph_clk_low,
    input  wire logic       periph_ack,
    input  wire logic       fault_low,
    output logic            peripheral_busy
);
    localparam int LW = $clog2(DEPTH) + 1;
    localparam logic [15:0] STB_CNT = 16'(STROBE_CYCLES);

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic clk_s, pack_s, fault_s, busy_s;
    ecpf_sync #(.INIT(1'b1)) u_sclk  (.mclk(mclk), .rst(rst), .pin(periph_clk_low), .level(clk_s));
    ecpf_sync #(.INIT(1'b1)) u_spack (.mclk(mclk), .rst(rst), .pin(periph_ack), .level(pack_s));
    ecpf_sync #(.INIT(1'b1)) u_sflt  (.mclk(mclk), .rst(rst), .pin(fault_low), .level(fault_s));
    assign busy_s = pack_s;

    // -----------------------------------------------------------------
    // byte queue shared by both directions
    // -----------------------------------------------------------------
    logic        active, fwd, rev, flush;
    ecpf_entry_s q_in, q_out;
    logic        q_in_valid, q_in_ready, q_out_valid, q_out_ready;
    logic [LW-1:0] q_level;

    // fifo held flushed outside fifo/ecp modes
    assign active = (mode == MODE_ECP) || (mode == MODE_FIFO);
    assign flush  = !active;
    assign fwd    = active && !direction;
    assign rev    = (mode == MODE_ECP) && direction;

    ecpf_fifo #(.WIDTH($bits(ecpf_entry_s)), .DEPTH(DEPTH)) u_queue (
        .mclk(mclk), .rst(rst), .flush(flush),
        .in_valid(q_in_valid), .in_ready(q_in_ready), .in_data(q_in),
        .out_valid(q_out_valid), .out_ready(q_out_ready), .out_data(q_out),
        .level(q_level)
    );

    // full and empty shown to the host
    assign queue_full  = !q_in_ready;
    assign queue_empty = !q_out_valid;
    assign peripheral_busy = busy_s;

    // -----------------------------------------------------------------
    // forward transmit: queue to pins
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_STB  = 3'b010,
        TX_WAIT = 3'b100
    } ecpf_tx_e;
    ecpf_tx_e  tx_q;
    logic [15:0] tx_cnt_q;
    logic [7:0]  pd_q;
    logic        hack_q;
    logic        stb_q;

    // host ack level carries the command/data kind
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_q     <= TX_IDLE;
            tx_cnt_q <= '0;
            pd_q     <= '0;
            hack_q   <= 1'b1;
            stb_q    <= 1'b1;
        end else if (!fwd) begin
            tx_q   <= TX_IDLE;
            stb_q  <= 1'b1;
            hack_q <= 1'b1;
        end else begin
            unique case (tx_q)
                TX_IDLE: begin
                    if (q_out_valid && !busy_s) begin
                        pd_q     <= q_out.value;
                        hack_q   <= !q_out.is_cmd;
                        stb_q    <= 1'b0;
                        tx_cnt_q <= STB_CNT;
                        tx_q     <= TX_STB;
                    end
                end
                TX_STB: begin
                    if (tx_cnt_q <= 16'h0001) begin
                        stb_q <= 1'b1;
                        tx_q  <= TX_WAIT;
                    end else begin
                        tx_cnt_q <= tx_cnt_q - 16'h0001;
                    end
                end
                TX_WAIT: begin
                    if (!busy_s) begin
                        tx_q <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // reverse receive with run-length expansion
    // -----------------------------------------------------------------
    logic       clk_d1_q;
    logic       rx_fall;
    logic [7:0] rep_left_q;
    logic [7:0] rep_byte_q;
    logic       rep_q;
    logic [6:0] run_q;
    logic       run_pend_q;
    logic       rx_hold_q;   // host ack low holds off peripheral while full

    assign rx_fall = clk_d1_q && !clk_s;

    // capture bytes; command low ack, run count expands next byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk_d1_q   <= 1'b1;
            rep_left_q <= '0;
            rep_byte_q <= '0;
            rep_q      <= 1'b0;
            run_q      <= RUN_ZERO;
            run_pend_q <= 1'b0;
        end else begin
            clk_d1_q <= clk_s;
            if (!rev) begin
                rep_q      <= 1'b0;
                run_pend_q <= 1'b0;
            end else if (rep_q) begin
                if (q_in_ready) begin
                    rep_left_q <= rep_left_q - 8'h01;
                    if (rep_left_q == 8'h01) begin
                        rep_q <= 1'b0;
                    end
                end
            end else if (rx_fall && !pack_s) begin
                if (!pd_in[CMD_KIND_BIT]) begin
                    run_q      <= pd_in[6:0];
                    run_pend_q <= 1'b1;
                end
            end else if (rx_fall && run_pend_q) begin
                rep_byte_q <= pd_in;
                rep_left_q <= {1'b0, run_q} + 8'h01;
                rep_q      <= 1'b1;
                run_pend_q <= 1'b0;
            end
        end
    end

    // handshake stalls while the queue is full
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_hold_q <= 1'b0;
        end else begin
            rx_hold_q <= rev && (!q_in_ready || rep_q);
        end
    end

    // -----------------------------------------------------------------
    // queue input mux: host writes forward, pins reverse
    // -----------------------------------------------------------------
    // writes never stall; a write to a full queue is dropped
    always_comb begin
        q_in       = '0;
        q_in_valid = 1'b0;
        if (fwd) begin
            q_in.value  = host_wdata;
            q_in.is_cmd = command_byte_queue_port && (mode == MODE_ECP);
            q_in_valid  = command_byte_queue_port || data_byte_queue_port || dma_ack;
        end else if (rev) begin
            if (rep_q) begin
                q_in.value = rep_byte_q;
                q_in_valid = 1'b1;
            end else if (rx_fall && pack_s && !run_pend_q) begin
                q_in.value = pd_in;
                q_in_valid = 1'b1;
            end
        end
    end
    assign q_out_ready = (fwd && tx_q == TX_IDLE && !busy_s)
                       || (rev && (host_read || dma_ack));

    // host read data registered
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            host_rdata <= '0;
        end else if (rev && (host_read || dma_ack)) begin
            host_rdata <= q_out.value;
        end
    end

    // -----------------------------------------------------------------
    // pin drivers
    // -----------------------------------------------------------------
    // open drain control lines in standard mode
    assign pd_out         = pd_q;
    assign pd_oe          = !direction;
    assign strobe_low_out = (mode == MODE_STD) ? 1'b0 : stb_q;
    assign strobe_low_oe  = (mode == MODE_STD) ? !stb_q : 1'b1;
    assign host_ack_out   = (mode == MODE_STD) ? 1'b0 : (rev ? !rx_hold_q : hack_q);
    assign host_ack_oe    = (mode == MODE_STD) ? !hack_q : 1'b1;

    // -----------------------------------------------------------------
    // service requests: threshold, dma and terminal count
    // -----------------------------------------------------------------
    logic [LW-1:0] thresh;
    logic          pio_cond, svc_cond, svc_d1_q;
    logic          tc_mask_q, mask_eff;
    logic [5:0]    burst_q;
    logic          svc_irq_q, ack_irq_q, flt_irq_q;
    logic          pack_d1_q, flt_d1_q, ferr_en_d1_q;

    // effective threshold is setting plus one
    assign thresh   = LW'(queue_trigger_setting) + LW'(LEVEL_ONE);
    assign mask_eff = service_interrupt_mask || tc_mask_q;
    assign mask_set = mask_eff;

    assign pio_cond = !dma_request_enable && active &&
                      (direction ? (q_level >= thresh)
                                 : ((LW'(DEPTH) - q_level) >= thresh));
    assign svc_cond = !mask_eff && pio_cond;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tc_mask_q <= 1'b0;
        end else if (service_interrupt_mask) begin
            tc_mask_q <= 1'b0;
        end else if (dma_ack && dma_tc && dma_request_enable && !mask_eff) begin
            tc_mask_q <= 1'b1;
        end
    end

    // count back to back dma cycles, drop after 32
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            burst_q <= '0;
        end else if (!dma_request) begin
            burst_q <= '0;
        end else if (dma_ack) begin
            burst_q <= burst_q + BURST_ONE;
        end
    end

    // request while queue has room or data, unmasked
    assign dma_request = dma_request_enable && !mask_eff && active &&
                         (burst_q < 6'(DMA_BURST_MAX)) &&
                         (rev ? q_out_valid : (fwd && q_in_ready));

    // edge and level service events, held one cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            svc_d1_q     <= 1'b0;
            pack_d1_q    <= 1'b1;
            flt_d1_q     <= 1'b1;
            ferr_en_d1_q <= 1'b1;
            svc_irq_q    <= 1'b0;
            ack_irq_q    <= 1'b0;
            flt_irq_q    <= 1'b0;
        end else begin
            svc_d1_q     <= svc_cond;
            pack_d1_q    <= pack_s;
            flt_d1_q     <= fault_s;
            ferr_en_d1_q <= fault_irq_enable_low;
            svc_irq_q    <= (svc_cond && !svc_d1_q)
                         || (dma_ack && dma_tc && dma_request_enable && !mask_eff);
            ack_irq_q    <= acknowledge_irq_enable && !pack_d1_q && pack_s;
            flt_irq_q    <= !fault_irq_enable_low &&
                            ((flt_d1_q && !fault_s) || (ferr_en_d1_q && !fault_s));
        end
    end

    // level output: pio condition stays asserted while true
    assign irq = svc_irq_q || ack_irq_q || flt_irq_q || svc_cond;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_mask_blocks_dma: assert property (@(posedge mclk) disable iff (rst)
        service_interrupt_mask |-> !dma_request) else $error("dma with mask set");
    a_tc_sets_mask: assert property (@(posedge mclk) disable iff (rst)
        (dma_ack && dma_tc && dma_request_enable && !mask_eff) |=> mask_set && irq)
        else $error("tc did not mask");
    a_burst_limit: assert property (@(posedge mclk) disable iff (rst)
        burst_q <= 6'(DMA_BURST_MAX)) else $error("dma burst too long");
    a_od_standard: assert property (@(posedge mclk) disable iff (rst)
        (mode == MODE_STD) |-> !strobe_low_out && !host_ack_out)
        else $error("push pull in mode 000");
    a_flush_idle: assert property (@(posedge mclk) disable iff (rst)
        !active |=> queue_empty) else $error("fifo live outside fifo modes");
    a_ack_rise_irq: assert property (@(posedge mclk) disable iff (rst)
        (acknowledge_irq_enable && $rose(pack_s)) |=> irq)
        else $error("ack edge lost");
    a_fault_irq: assert property (@(posedge mclk) disable iff (rst)
        (!fault_irq_enable_low && $fell(fault_s)) |=> irq)
        else $error("fault edge lost");
    a_pio_level: assert property (@(posedge mclk) disable iff (rst)
        svc_cond |-> irq) else $error("pio service missing");
    a_rev_fill: assert property (@(posedge mclk) disable iff (rst)
        (!mask_eff && !dma_request_enable && rev && q_level >= thresh) |-> irq)
        else $error("fill service missing");
    a_unmask_irq: assert property (@(posedge mclk) disable iff (rst)
        ($fell(mask_eff) && pio_cond) |-> irq) else $error("unmask no irq");
endmodule

// >>> tb/ecpf_periph_model.sv
// ecpf_periph_model: behavioural ecp peripheral on the far side of the pins
// assumes the engine drives strobe, host ack and data; one clock, mclk
`timescale 1ns/1ps
module ecpf_periph_model (
    input  wire logic       mclk,
    input  wire logic       strobe_low_out,
    input  wire logic       host_ack_out,
    input  wire logic [7:0] pd_out,
    output logic [7:0]      pd_in,
    output logic            periph_ack,
    output logic            periph_clk_low
);
    logic [8:0] rx_q[$];  // {host ack, byte} per forward byte
    logic [1:0] low_cnt = 2'h0;
    // ---------------------------------------------------------------
    // forward capture
    // ---------------------------------------------------------------
    // sample two cycles into the strobe so data and ack have settled
    always @(posedge mclk) begin
        low_cnt <= strobe_low_out ? 2'h0 : (low_cnt == 2'h3 ? low_cnt : low_cnt + 2'h1);
        if (!strobe_low_out && low_cnt == 2'h2) begin
            rx_q.push_back({host_ack_out, pd_out});
        end
    end
    initial begin
        pd_in          = 8'h00;
        periph_ack     = 1'b0;
        periph_clk_low = 1'b1;
    end
    // ---------------------------------------------------------------
    // reverse send
    // ---------------------------------------------------------------
    task automatic send_byte(input logic is_cmd, input logic [7:0] b);
        @(posedge mclk);
        pd_in <= b;
        periph_ack <= !is_cmd;
        repeat (3) @(posedge mclk);
        periph_clk_low <= 1'b0;
        repeat (12) @(posedge mclk);
        periph_clk_low <= 1'b1;
        repeat (12) @(posedge mclk);
        pd_in <= ~b;  // released lines do not keep the old value
        periph_ack <= 1'b0;
    endtask
endmodule

// >>> tb/ecp_parallel_port_fifo_engine_bench.sv
// bench for ecpf_engine: hand written scenarios, each judging its own result
// assumes the peripheral model answers at the pins; mclk 250 MHz
`timescale 1ns/1ps
module ecp_parallel_port_fifo_engine_bench;
    import ecpf_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, direction, service_interrupt_mask, dma_request_enable;
    logic fault_irq_enable_low, acknowledge_irq_enable, command_byte_queue_port;
    logic data_byte_queue_port, host_read, dma_ack, dma_tc, fault_low;
    logic [2:0] mode;
    logic [3:0] queue_trigger_setting;
    logic [7:0] host_wdata, host_rdata, pd_in, pd_out;
    logic dma_request, mask_set, irq, queue_full, queue_empty, pd_oe, strobe_low_out;
    logic strobe_low_oe, host_ack_out, host_ack_oe, periph_clk_low, periph_ack;
    int errors = 0, check_count = 0;
    always #2 mclk = ~mclk;
    ecpf_engine u_ecpf_engine (.mclk(mclk), .rst(rst), .mode(mode), .direction(direction),
        .service_interrupt_mask(service_interrupt_mask), .dma_request_enable(dma_request_enable),
        .fault_irq_enable_low(fault_irq_enable_low),
        .acknowledge_irq_enable(acknowledge_irq_enable),
        .queue_trigger_setting(queue_trigger_setting),
        .command_byte_queue_port(command_byte_queue_port),
        .data_byte_queue_port(data_byte_queue_port), .host_wdata(host_wdata),
        .host_read(host_read), .host_rdata(host_rdata), .dma_ack(dma_ack), .dma_tc(dma_tc),
        .dma_request(dma_request), .mask_set(mask_set), .irq(irq), .queue_full(queue_full),
        .queue_empty(queue_empty), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
        .strobe_low_out(strobe_low_out), .strobe_low_oe(strobe_low_oe),
        .host_ack_out(host_ack_out), .host_ack_oe(host_ack_oe),
        .periph_clk_low(periph_clk_low), .periph_ack(periph_ack), .fault_low(fault_low),
        .peripheral_busy());
    ecpf_periph_model u_ecpf_periph_model (.mclk(mclk),
        .strobe_low_out(strobe_low_out | !strobe_low_oe),
        .host_ack_out(host_ack_out | !host_ack_oe), .pd_out(pd_out), .pd_in(pd_in),
        .periph_ack(periph_ack), .periph_clk_low(periph_clk_low));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic setup(input logic [2:0] m, input logic d, input logic msk, input logic en);
        @(posedge mclk);
        mode <= m;
        direction <= d;
        service_interrupt_mask <= msk;
        dma_request_enable <= en;
        repeat (3) @(posedge mclk);
    endtask
    task automatic hw(input logic cmd, input logic [7:0] b);
        @(posedge mclk);
        command_byte_queue_port <= cmd;
        data_byte_queue_port <= !cmd;
        host_wdata <= b;
        @(posedge mclk);
        command_byte_queue_port <= 1'b0;
        data_byte_queue_port <= 1'b0;
    endtask
    task automatic hr(input logic [7:0] exp);
        @(posedge mclk);
        host_read <= 1'b1;
        @(posedge mclk);
        host_read <= 1'b0;
        @(posedge mclk);
        #1 chk("host_rdata", {1'b0, exp}, {1'b0, host_rdata});
    endtask
    // a bounded watch for an interrupt pulse after an event pin change
    task automatic see_irq(input string what);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(posedge mclk);
            #1 seen = seen | irq;
        end
        chk(what, 9'h001, {8'h00, seen});
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_forward();
        setup(MODE_ECP, 1'b0, 1'b1, 1'b0);
        hw(1'b1, 8'h85);
        hw(1'b0, 8'h3c);
        hw(1'b1, 8'h05);
        for (int i = 0; i < 600 && u_ecpf_periph_model.rx_q.size() < 3; i++) @(posedge mclk);
        if (u_ecpf_periph_model.rx_q.size() < 3) begin
            errors++;
            close_out();
        end
        chk("fwd address", 9'h085, u_ecpf_periph_model.rx_q[0]);
        chk("fwd data", 9'h13c, u_ecpf_periph_model.rx_q[1]);
        chk("fwd run count", 9'h005, u_ecpf_periph_model.rx_q[2]);
        chk("fwd empty", 9'h001, {8'h00, queue_empty});
        $display("test forward done");
    endtask
    task automatic t_pio_service();
        queue_trigger_setting <= 4'h3;
        setup(MODE_ECP, 1'b0, 1'b1, 1'b0);
        chk("masked irq", 9'h000, {8'h00, irq});
        service_interrupt_mask <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("unmask irq", 9'h001, {8'h00, irq});
        $display("test pio service done");
    endtask
    task automatic t_reverse();
        setup(MODE_BIDIR, 1'b1, 1'b1, 1'b0);
        setup(MODE_ECP, 1'b1, 1'b0, 1'b0);
        u_ecpf_periph_model.send_byte(1'b1, 8'h03);
        u_ecpf_periph_model.send_byte(1'b0, 8'ha5);
        repeat (8) @(posedge mclk);
        #1 chk("fill irq", 9'h001, {8'h00, irq});
        chk("rev not empty", 9'h000, {7'h00, queue_full, queue_empty});
        @(posedge mclk);
        service_interrupt_mask <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk("mask irq", 9'h000, {8'h00, irq});
        for (int i = 0; i < 4; i++) hr(8'ha5);
        chk("rev drained", 9'h001, {8'h00, queue_empty});
        $display("test reverse done");
    endtask
    task automatic t_dma_tc();
        setup(MODE_ECP, 1'b1, 1'b0, 1'b1);
        u_ecpf_periph_model.send_byte(1'b0, 8'h11);
        u_ecpf_periph_model.send_byte(1'b0, 8'h22);
        repeat (4) @(posedge mclk);
        #1 chk("dma request", 9'h001, {8'h00, dma_request});
        @(posedge mclk);
        dma_ack <= 1'b1;
        dma_tc <= 1'b1;
        @(posedge mclk);
        dma_ack <= 1'b0;
        dma_tc <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("tc mask", 9'h001, {8'h00, mask_set});
        chk("tc stops request", 9'h000, {8'h00, dma_request});
        setup(MODE_ECP, 1'b1, 1'b1, 1'b1);
        setup(MODE_ECP, 1'b1, 1'b0, 1'b1);
        chk("re request", 9'h001, {8'h00, dma_request});
        $display("test dma done");
    endtask
    task automatic t_pins();
        setup(MODE_BIDIR, 1'b0, 1'b1, 1'b0);
        setup(MODE_STD, 1'b0, 1'b1, 1'b0);
        #1 chk("std strobe oe", 9'h000, {8'h00, strobe_low_oe});
        chk("std hack oe", 9'h000, {8'h00, host_ack_oe});
        @(posedge mclk);
        fault_irq_enable_low <= 1'b0;
        @(posedge mclk);
        fault_low <= 1'b0;
        see_irq("fault irq");
        setup(MODE_ECP, 1'b0, 1'b1, 1'b0);
        #1 chk("ecp strobe drv", 9'h007, {6'h00, pd_oe, strobe_low_oe, strobe_low_out});
        $display("test pins done");
    endtask
    initial begin
        {direction, service_interrupt_mask, dma_request_enable} = 3'h4;
        {acknowledge_irq_enable, command_byte_queue_port, data_byte_queue_port} = 3'h4;
        {host_read, dma_ack, dma_tc} = 3'h0;
        fault_irq_enable_low = 1'b1;
        fault_low = 1'b1;
        mode = MODE_STD;
        queue_trigger_setting = 4'h0;
        host_wdata = 8'h00;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        #1 chk("reset empty", 9'h001, {8'h00, queue_empty});
        chk("reset outs", 9'h000, {7'h00, dma_request, irq});
        t_forward();
        t_pio_service();
        t_reverse();
        t_dma_tc();
        t_pins();
        close_out();
    end
endmodule
